// ---- rtl/adcc_cfg.svh ----
/*
 * Constants of the converter control and interrupt flag block:
 * widths, register offsets, field positions and reset values.
 * Assumes it is included by bare name from the block's design files.
 */
`ifndef ADCC_CFG_SVH
`define ADCC_CFG_SVH

// ****************************************************************
// Widths.
// ****************************************************************
`define ADCC_AW            8
`define ADCC_DW            16
`define ADCC_NIRQ          9

// ****************************************************************
// Register offsets.
// ****************************************************************
`define ADCC_OFF_CTRL      8'h00
`define ADCC_OFF_FLAGS     8'h04
`define ADCC_OFF_FLAG_CLR  8'h05
`define ADCC_OFF_CONT      8'h08
`define ADCC_OFF_EVT_STAT  8'h09
`define ADCC_OFF_EVT_CLR   8'h0a
`define ADCC_OFF_EVT_EN    8'h0b

// ****************************************************************
// Fields of the first control register.
// ****************************************************************
`define ADCC_BIT_BANDGAP   6
`define ADCC_BIT_REFBUF    5
`define ADCC_BIT_RSVD      4
`define ADCC_BIT_REFSEL    3
`define ADCC_BIT_PULSEPOS  2
`define ADCC_BIT_LOWREF    1
`define ADCC_BIT_TEMP      0
`define ADCC_CTRL_WMASK    16'h006f
`define ADCC_CTRL_RESET    16'h0000

// ****************************************************************
// Reset values of the interrupt side and the read port.
// ****************************************************************
`define ADCC_IRQ_RESET     9'h000
`define ADCC_RD_RESET      16'h0000

`endif

// ---- rtl/adcc_pkg.sv ----
/*
 * Types of the converter control and interrupt flag block.
 * Assumes adcc_cfg.svh is on the include path.
 */
`include "adcc_cfg.svh"

package adcc_pkg;

    // ************************************************************
    // Types.
    // ************************************************************
    typedef logic [`ADCC_NIRQ-1:0] adcc_irq_t;
    typedef logic [`ADCC_DW-1:0]   adcc_word_t;
    typedef logic [`ADCC_AW-1:0]   adcc_addr_t;

    typedef enum logic [0:0] {
        ADCC_POS_CONV_START   = 1'b0,
        ADCC_POS_BEFORE_LATCH = 1'b1
    } adcc_pulse_pos_e;

endpackage

// ---- rtl/adcc_irq_flag.sv ----
/*
 * One converter interrupt flag with its pulse and overflow event.
 * Assumes trigger and clear are one-cycle pulses on ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module adcc_irq_flag (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic trigger,
    input  wire logic clear,
    input  wire logic contMode,
    output var  logic flag,
    output var  logic pulse,
    output var  logic overflow
);

    logic next_flag;
    logic next_pulse;
    logic next_overflow;

    // ************************************************************
    // Flag, pulse and overflow.
    // ************************************************************
    always_comb begin
        next_pulse    = trigger && (!flag || contMode);
        next_overflow = trigger && flag && !contMode && !clear;
        if (trigger) begin
            next_flag = 1'b1;
        end else if (clear) begin
            next_flag = 1'b0;
        end else begin
            next_flag = flag;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            flag     <= 1'b0;
            pulse    <= 1'b0;
            overflow <= 1'b0;
        end else begin
            flag     <= next_flag;
            pulse    <= next_pulse;
            overflow <= next_overflow;
        end
    end

endmodule

`default_nettype wire

// ---- rtl/adcc_top.sv ----
/*
 * Control register and interrupt flag register of the converter,
 * with interrupt pulse generation and an overflow event interrupt.
 * Assumes the sequencer signals come from logic on ref_clk and that
 * software reaches the registers over a plain strobe port.
 */
// Behaviour
// RQ1 - Bandgap is powered only while control bit 6 is one.
// RQ2 - Reference buffers are powered only while control bit 5 is one.
// RQ3 - Control bit 4 reads zero and ignores writes.
// RQ4 - Bit 3 picks external references; shared high-reference input lost.
// RQ5 - With bit 2 clear, pulse comes at the sample pulse falling edge.
// RQ6 - With bit 2 set, pulse comes one cycle before result latching.
// RQ7 - Bit 1 routes the low reference to channel B5 instead of its pin.
// RQ8 - Software keeps the temperature sensor bit 0 at zero.
// RQ9 - Flag register holds nine read-only flags; upper bits read zero.
// RQ10 - Each flag is set when its interrupt pulse is generated.
// RQ11 - Hardware set beats software clear; overflow then untouched.
// RQ12 - Without continuous mode a set flag blocks pulses, records overflow.
`timescale 1ns/1ps
`default_nettype none
`include "adcc_cfg.svh"

module adcc_top
    import adcc_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire adcc_addr_t addr,
    input  wire adcc_word_t wrData,
    input  wire logic       wrEn,
    input  wire logic       rdEn,
    output var  adcc_word_t rdData,
    input  wire logic       sampleActive,
    input  wire logic       resultLatchAhead,
    input  wire adcc_irq_t  eocSelect,
    output var  logic       bandgapPowerOn,
    output var  logic       refBufferPowerOn,
    output var  logic       refExternal,
    output var  logic       inputAZeroAvailable,
    output var  logic       lowRefConvert,
    output var  logic       tempSensorConvert,
    output var  adcc_irq_t  convIrqPulse,
    output var  logic       irqOut
);

    // ************************************************************
    // Declarations.
    // ************************************************************
    adcc_word_t ctrl;
    adcc_word_t next_ctrl;
    adcc_irq_t  contMode;
    adcc_irq_t  next_contMode;
    adcc_irq_t  evtStat;
    adcc_irq_t  next_evtStat;
    adcc_irq_t  evtEn;
    adcc_irq_t  next_evtEn;
    adcc_word_t next_rdData;
    logic       prevSample;
    logic       sampleFall;
    logic       pulseMoment;
    adcc_irq_t  trig;
    adcc_irq_t  flagClr;
    adcc_irq_t  evtClr;
    adcc_irq_t  convIrqFlag;
    adcc_irq_t  ovfEvent;
    adcc_pulse_pos_e pulsePos;

    // ************************************************************
    // Control, continuous mode and event enable registers.
    // ************************************************************
    always_comb begin
        next_ctrl     = ctrl;
        next_contMode = contMode;
        next_evtEn    = evtEn;
        if (wrEn && addr == `ADCC_OFF_CTRL) begin
            next_ctrl = wrData & `ADCC_CTRL_WMASK; // see RQ3
        end
        if (wrEn && addr == `ADCC_OFF_CONT) begin
            next_contMode = wrData[`ADCC_NIRQ-1:0];
        end
        if (wrEn && addr == `ADCC_OFF_EVT_EN) begin
            next_evtEn = wrData[`ADCC_NIRQ-1:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl     <= `ADCC_CTRL_RESET;
            contMode <= `ADCC_IRQ_RESET;
            evtEn    <= `ADCC_IRQ_RESET;
        end else begin
            ctrl     <= next_ctrl;
            contMode <= next_contMode;
            evtEn    <= next_evtEn;
        end
    end

    // ************************************************************
    // Analog core controls.
    // ************************************************************
    assign bandgapPowerOn      = ctrl[`ADCC_BIT_BANDGAP]; // see RQ1
    assign refBufferPowerOn    = ctrl[`ADCC_BIT_REFBUF]; // see RQ2
    assign refExternal         = ctrl[`ADCC_BIT_REFSEL]; // see RQ4
    assign inputAZeroAvailable = !ctrl[`ADCC_BIT_REFSEL]; // see RQ4
    assign lowRefConvert       = ctrl[`ADCC_BIT_LOWREF]; // see RQ7
    assign tempSensorConvert   = ctrl[`ADCC_BIT_TEMP];
    assign pulsePos = adcc_pulse_pos_e'(ctrl[`ADCC_BIT_PULSEPOS]);

    // ************************************************************
    // Pulse timing.
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            prevSample <= 1'b0;
        end else begin
            prevSample <= sampleActive;
        end
    end

    always_comb begin
        sampleFall = prevSample && !sampleActive;
        unique case (pulsePos)
            ADCC_POS_CONV_START: begin
                pulseMoment = sampleFall; // see RQ5
            end
            ADCC_POS_BEFORE_LATCH: begin
                pulseMoment = resultLatchAhead; // see RQ6
            end
        endcase
    end

    // ************************************************************
    // Interrupt flags.
    // ************************************************************
    always_comb begin
        trig    = eocSelect & {`ADCC_NIRQ{pulseMoment}};
        flagClr = {`ADCC_NIRQ{1'b0}};
        evtClr  = {`ADCC_NIRQ{1'b0}};
        if (wrEn && addr == `ADCC_OFF_FLAG_CLR) begin
            flagClr = wrData[`ADCC_NIRQ-1:0];
        end
        if (wrEn && addr == `ADCC_OFF_EVT_CLR) begin
            evtClr = wrData[`ADCC_NIRQ-1:0];
        end
    end

    generate
        for (genvar i = 0; i < `ADCC_NIRQ; i++) begin : g_flag
            // Set beats clear; a set flag blocks pulses unless its contMode bit is one.
            adcc_irq_flag u_flag ( // see RQ10 RQ11 RQ12
                .ref_clk  (ref_clk),
                .rst_n    (rst_n),
                .trigger  (trig[i]),
                .clear    (flagClr[i]),
                .contMode (contMode[i]),
                .flag     (convIrqFlag[i]),
                .pulse    (convIrqPulse[i]),
                .overflow (ovfEvent[i])
            );
        end
    endgenerate

    // ************************************************************
    // Overflow event status and interrupt line.
    // ************************************************************
    always_comb begin
        next_evtStat = (evtStat & ~evtClr) | ovfEvent;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            evtStat <= `ADCC_IRQ_RESET;
        end else begin
            evtStat <= next_evtStat;
        end
    end

    assign irqOut = |(evtStat & evtEn);

    // ************************************************************
    // Read port.
    // ************************************************************
    always_comb begin
        next_rdData = `ADCC_RD_RESET;
        if (rdEn) begin
            unique case (addr)
                `ADCC_OFF_CTRL: begin
                    next_rdData = ctrl; // see RQ3
                end
                `ADCC_OFF_FLAGS: begin
                    next_rdData = {7'h00, convIrqFlag}; // see RQ9
                end
                `ADCC_OFF_CONT: begin
                    next_rdData = {7'h00, contMode};
                end
                `ADCC_OFF_EVT_STAT: begin
                    next_rdData = {7'h00, evtStat};
                end
                `ADCC_OFF_EVT_EN: begin
                    next_rdData = {7'h00, evtEn};
                end
                default: begin
                    next_rdData = `ADCC_RD_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rdData <= `ADCC_RD_RESET;
        end else begin
            rdData <= next_rdData;
        end
    end

    // ************************************************************
    // Assertions.
    // ************************************************************
    property p_bandgap;
        @(posedge ref_clk) disable iff (!rst_n)
        wrEn && addr == `ADCC_OFF_CTRL
        |=> bandgapPowerOn == $past(wrData[`ADCC_BIT_BANDGAP]);
    endproperty
    a_bandgap: assert property (p_bandgap) // see RQ1
        else $error("Bandgap power does not follow control bit.");

    property p_refbuf;
        @(posedge ref_clk) disable iff (!rst_n)
        wrEn && addr == `ADCC_OFF_CTRL
        |=> refBufferPowerOn == $past(wrData[`ADCC_BIT_REFBUF]);
    endproperty
    a_refbuf: assert property (p_refbuf) // see RQ2
        else $error("Reference buffer power does not follow bit.");

    property p_rsvd;
        @(posedge ref_clk) disable iff (!rst_n)
        rdEn && addr == `ADCC_OFF_CTRL |=> !rdData[`ADCC_BIT_RSVD];
    endproperty
    a_rsvd: assert property (p_rsvd) // see RQ3
        else $error("Reserved control bit reads as one.");

    property p_refsel;
        @(posedge ref_clk) disable iff (!rst_n)
        wrEn && addr == `ADCC_OFF_CTRL
        |=> refExternal == $past(wrData[`ADCC_BIT_REFSEL])
            && inputAZeroAvailable != refExternal;
    endproperty
    a_refsel: assert property (p_refsel) // see RQ4
        else $error("Reference select or shared input is wrong.");

    property p_pos_start;
        @(posedge ref_clk) disable iff (!rst_n)
        pulsePos == ADCC_POS_CONV_START && $fell(sampleActive)
            && eocSelect[0] && !convIrqFlag[0]
        |=> convIrqPulse[0];
    endproperty
    a_pos_start: assert property (p_pos_start) // see RQ5
        else $error("No pulse at conversion start.");

    property p_pos_latch;
        @(posedge ref_clk) disable iff (!rst_n)
        pulsePos == ADCC_POS_BEFORE_LATCH && resultLatchAhead
            && eocSelect[0] && !convIrqFlag[0]
        |=> convIrqPulse[0];
    endproperty
    a_pos_latch: assert property (p_pos_latch) // see RQ6
        else $error("No pulse before result latching.");

    property p_lowref;
        @(posedge ref_clk) disable iff (!rst_n)
        wrEn && addr == `ADCC_OFF_CTRL
        |=> lowRefConvert == $past(wrData[`ADCC_BIT_LOWREF]);
    endproperty
    a_lowref: assert property (p_lowref) // see RQ7
        else $error("Low reference routing does not follow bit.");

    property p_flag_read;
        @(posedge ref_clk) disable iff (!rst_n)
        rdEn && addr == `ADCC_OFF_FLAGS
        |=> rdData == {7'h00, $past(convIrqFlag)};
    endproperty
    a_flag_read: assert property (p_flag_read) // see RQ9
        else $error("Flag register read is wrong.");

    property p_flag_set;
        @(posedge ref_clk) disable iff (!rst_n)
        |convIrqPulse |-> (convIrqPulse & ~convIrqFlag) == 9'h000;
    endproperty
    a_flag_set: assert property (p_flag_set) // see RQ10
        else $error("Pulse without its flag set.");

    property p_set_wins;
        @(posedge ref_clk) disable iff (!rst_n)
        trig[0] && flagClr[0] |=> convIrqFlag[0] && !ovfEvent[0];
    endproperty
    a_set_wins: assert property (p_set_wins) // see RQ11
        else $error("Clear beat a hardware set.");

    property p_overflow;
        @(posedge ref_clk) disable iff (!rst_n)
        trig[0] && convIrqFlag[0] && !contMode[0] && !flagClr[0]
        |=> !convIrqPulse[0] ##1 evtStat[0];
    endproperty
    a_overflow: assert property (p_overflow) // see RQ12
        else $error("Set flag did not block pulse or log overflow.");

    c_pulse: cover property (@(posedge ref_clk) disable iff (!rst_n)
        convIrqPulse[0]);
    c_overflow: cover property (@(posedge ref_clk) disable iff (!rst_n)
        ovfEvent[0] ##1 irqOut);
    c_set_clear: cover property (@(posedge ref_clk) disable iff (!rst_n)
        trig[0] && flagClr[0]);

endmodule

`default_nettype wire

// ---- tb/adcc_top_tb.sv ----
/*
 * Self-checking bench of the converter control and flag registers.
 * Assumes adcc_pkg is compiled first and adcc_cfg.svh is included.
 */
`timescale 1ns/1ps
`default_nettype none
`include "adcc_cfg.svh"

module adcc_top_tb
    import adcc_pkg::*;
;
    logic       ref_clk;
    logic       rst_n;
    adcc_addr_t addr;
    adcc_word_t wrData;
    logic       wrEn;
    logic       rdEn;
    adcc_word_t rdData;
    logic       sampleActive;
    logic       resultLatchAhead;
    adcc_irq_t  eocSelect;
    logic       bandgapPowerOn;
    logic       refBufferPowerOn;
    logic       refExternal;
    logic       inputAZeroAvailable;
    logic       lowRefConvert;
    logic       tempSensorConvert;
    adcc_irq_t  convIrqPulse;
    logic       irqOut;
    adcc_word_t rd;
    int         numErrors;
    int         testsRun;

    adcc_top dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wrData(wrData),
        .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData),
        .sampleActive(sampleActive), .resultLatchAhead(resultLatchAhead),
        .eocSelect(eocSelect), .bandgapPowerOn(bandgapPowerOn),
        .refBufferPowerOn(refBufferPowerOn), .refExternal(refExternal),
        .inputAZeroAvailable(inputAZeroAvailable),
        .lowRefConvert(lowRefConvert),
        .tempSensorConvert(tempSensorConvert),
        .convIrqPulse(convIrqPulse), .irqOut(irqOut)
    );

    always #4 ref_clk = ~ref_clk;

    // ************************************************************
    // Compare, bus and event tasks.
    // ************************************************************
    task automatic check_word(input adcc_word_t got, input adcc_word_t exp,
                              input string msg);
        testsRun++;
        if (got !== exp) begin
            numErrors++;
            $display("unexpected at %0t: %s got %h exp %h", $time, msg,
                     got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp,
                             input string msg);
        testsRun++;
        if (got !== exp) begin
            numErrors++;
            $display("unexpected at %0t: %s got %b", $time, msg, got);
        end
    endtask

    task automatic reg_write(input adcc_addr_t a, input adcc_word_t d);
        @(posedge ref_clk);
        addr   <= a;
        wrData <= d;
        wrEn   <= 1'b1;
        @(posedge ref_clk);
        wrEn   <= 1'b0;
        #1;
    endtask

    task automatic reg_read(input adcc_addr_t a, output adcc_word_t d);
        @(posedge ref_clk);
        addr <= a;
        rdEn <= 1'b1;
        @(posedge ref_clk);
        rdEn <= 1'b0;
        #1;
        d = rdData;
    endtask

    // Leaves the time just after the edge that takes the trigger.
    task automatic fire_latch(input adcc_irq_t sel);
        @(posedge ref_clk);
        resultLatchAhead <= 1'b1;
        eocSelect        <= sel;
        @(posedge ref_clk);
        resultLatchAhead <= 1'b0;
        #1;
    endtask

    task automatic fire_sample(input adcc_irq_t sel);
        @(posedge ref_clk);
        sampleActive <= 1'b1;
        eocSelect    <= sel;
        @(posedge ref_clk);
        sampleActive <= 1'b0;
        @(posedge ref_clk);
        #1;
    endtask

    task automatic check_pulse(input adcc_irq_t exp);
        check_word({7'h00, convIrqPulse}, {7'h00, exp}, "pulse");
    endtask

    task automatic wait_check_irq(input logic exp);
        @(posedge ref_clk);
        #1;
        check_bit(irqOut, exp, "irqOut");
    endtask

    // ************************************************************
    // Scenarios.
    // ************************************************************
    task automatic test_reset();
        reg_read(`ADCC_OFF_CTRL, rd);
        check_word(rd, 16'h0000, "ctrl reset");
        reg_read(`ADCC_OFF_FLAGS, rd);
        check_word(rd, 16'h0000, "flags reset");
        check_bit(inputAZeroAvailable, 1'b1, "a0 reset");
        check_bit(bandgapPowerOn, 1'b0, "bandgap reset");
        check_bit(irqOut, 1'b0, "irq reset");
    endtask

    task automatic test_ctrl();
        reg_write(`ADCC_OFF_CTRL, 16'hfffe);
        check_bit(bandgapPowerOn, 1'b1, "bandgap on");
        check_bit(refBufferPowerOn, 1'b1, "refbuf on");
        check_bit(refExternal, 1'b1, "ref ext");
        check_bit(inputAZeroAvailable, 1'b0, "a0 lost");
        check_bit(lowRefConvert, 1'b1, "lowref on");
        reg_read(`ADCC_OFF_CTRL, rd);
        check_word(rd, 16'h006e, "ctrl mask");
        reg_write(`ADCC_OFF_CTRL, 16'h0040);
        check_bit(refBufferPowerOn, 1'b0, "refbuf off");
        check_bit(tempSensorConvert, 1'b0, "temp off");
        check_bit(inputAZeroAvailable, 1'b1, "a0 back");
        check_bit(refExternal, 1'b0, "ref int");
        reg_write(`ADCC_OFF_CTRL, 16'h0020);
        check_bit(bandgapPowerOn, 1'b0, "bandgap off");
        check_bit(lowRefConvert, 1'b0, "lowref off");
        reg_write(8'h30, 16'hffff);
        reg_read(8'h30, rd);
        check_word(rd, 16'h0000, "unmapped");
        reg_write(`ADCC_OFF_FLAGS, 16'h01ff);
        reg_read(`ADCC_OFF_FLAGS, rd);
        check_word(rd, 16'h0000, "flags ro");
        reg_read(`ADCC_OFF_CTRL, rd);
        check_word(rd, 16'h0020, "ctrl kept");
    endtask

    task automatic test_pos_start();
        reg_write(`ADCC_OFF_CTRL, 16'h0000);
        fire_latch(9'h001);
        check_pulse(9'h000);
        fire_sample(9'h001);
        check_pulse(9'h001);
        @(posedge ref_clk);
        #1;
        check_pulse(9'h000);
        reg_read(`ADCC_OFF_FLAGS, rd);
        check_word(rd, 16'h0001, "flag0 set");
        @(posedge ref_clk);
        #1;
        check_word(rdData, 16'h0000, "rd one cycle");
        reg_write(`ADCC_OFF_FLAG_CLR, 16'h0001);
        reg_read(`ADCC_OFF_FLAGS, rd);
        check_word(rd, 16'h0000, "flag0 clr");
    endtask

    task automatic test_pos_latch();
        reg_write(`ADCC_OFF_CTRL, 16'h0004);
        fire_sample(9'h100);
        check_pulse(9'h000);
        fire_latch(9'h100);
        check_pulse(9'h100);
        reg_read(`ADCC_OFF_FLAGS, rd);
        check_word(rd, 16'h0100, "flag8 set");
    endtask

    task automatic test_overflow();
        reg_write(`ADCC_OFF_EVT_EN, 16'h0000);
        fire_latch(9'h100);
        check_pulse(9'h000);
        wait_check_irq(1'b0);
        reg_read(`ADCC_OFF_EVT_STAT, rd);
        check_word(rd, 16'h0100, "overflow set");
        reg_write(`ADCC_OFF_EVT_EN, 16'h0100);
        check_bit(irqOut, 1'b1, "irq enabled");
        reg_write(`ADCC_OFF_EVT_CLR, 16'h0100);
        check_bit(irqOut, 1'b0, "irq cleared");
        fire_latch(9'h100);
        wait_check_irq(1'b1);
        reg_write(`ADCC_OFF_EVT_CLR, 16'h0100);
        reg_write(`ADCC_OFF_CONT, 16'h0100);
        fire_latch(9'h100);
        check_pulse(9'h100);
        wait_check_irq(1'b0);
        reg_write(`ADCC_OFF_CONT, 16'h0000);
    endtask

    task automatic test_race();
        reg_write(`ADCC_OFF_EVT_EN, 16'h0001);
        fire_latch(9'h001);
        check_pulse(9'h001);
        @(posedge ref_clk);
        addr             <= `ADCC_OFF_FLAG_CLR;
        wrData           <= 16'h0001;
        wrEn             <= 1'b1;
        resultLatchAhead <= 1'b1;
        @(posedge ref_clk);
        wrEn             <= 1'b0;
        resultLatchAhead <= 1'b0;
        #1;
        check_pulse(9'h000);
        wait_check_irq(1'b0);
        reg_read(`ADCC_OFF_FLAGS, rd);
        check_word(rd, 16'h0101, "set wins");
        reg_read(`ADCC_OFF_EVT_STAT, rd);
        check_word(rd, 16'h0000, "no overflow");
        fire_latch(9'h001);
        check_pulse(9'h000);
        wait_check_irq(1'b1);
    endtask

    // Reset in mid-run clears irqOut and returns the flag and control registers to zero.
    task automatic test_mid_reset();
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        #1;
        check_bit(irqOut, 1'b0, "irq after reset");
        reg_read(`ADCC_OFF_FLAGS, rd);
        check_word(rd, 16'h0000, "flags after reset");
        reg_read(`ADCC_OFF_CTRL, rd);
        check_word(rd, 16'h0000, "ctrl after reset");
    endtask

    // ************************************************************
    // Verdict, watchdog and main sequence.
    // ************************************************************
    task automatic print_verdict();
        $display("errors %0d, checks %0d", numErrors, testsRun);
        if (numErrors == 0 && testsRun > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        #20000;
        numErrors++;
        print_verdict();
    end

    initial begin
        ref_clk          = 1'b0;
        rst_n            = 1'b0;
        addr             = 8'h00;
        wrData           = 16'h0000;
        wrEn             = 1'b0;
        rdEn             = 1'b0;
        sampleActive     = 1'b0;
        resultLatchAhead = 1'b0;
        eocSelect        = 9'h000;
        numErrors        = 0;
        testsRun         = 0;
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        test_reset();
        test_ctrl();
        test_pos_start();
        test_pos_latch();
        test_overflow();
        test_race();
        test_mid_reset();
        print_verdict();
    end
endmodule

`default_nettype wire
